// >>> hdl/acc_top.sv
// Functional notes
// (RULE1) Result high when positive exceeds negative
// (RULE2) Mux on, converter off: channel picks negative
// (RULE3) Otherwise dedicated negative pin is used
// (RULE4) Disable bit powers comparator down, always writable
// (RULE5) Software clears enable before toggling disable
// (RULE6) Bandgap select replaces positive pin input
// (RULE7) Result synchronised, one to two cycles
// (RULE8) Chosen event sets the interrupt flag
// (RULE9) Flag cleared by vector or writing one
// (RULE10) Request needs flag, enable and global enable
// (RULE11) Capture enable routes result to timer
// (RULE12) Capture disabled: timer sees no comparator
// (RULE13) Software also enables timer capture interrupt
// (RULE14) Mode: toggle, reserved, falling, rising
// (RULE15) Software disables interrupt before mode change
// (RULE16) Pin disable forces port input zero
// (RULE17) Software disables buffers on analog pins
// (RULE18) Control register at data 0x50, I/O 0x30
// (RULE19) Converter power reduction must be cleared
// (RULE20) Converter counts on only when enabled
// (RULE21) Events found by comparing with previous cycle
`timescale 1ns/100ps
module acc_top (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Register access port
  input wire logic [7:0] I_ADDR,
  input wire logic I_IO_SPACE,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  // Converter controls from elsewhere in the device
  input wire logic I_NEGATIVE_MUX_ENABLE,
  input wire logic I_CONVERTER_ENABLE,
  input wire logic [2:0] I_CHANNEL_SELECT_LOW,
  // Comparator analog model: raw comparison per candidate input
  input wire logic I_POS_GT_NEG_PIN,
  input wire logic [7:0] I_POS_GT_CHANNEL,
  input wire logic I_BANDGAP_GT_NEG_PIN,
  input wire logic [7:0] I_BANDGAP_GT_CHANNEL,
  // Comparator analog control
  output logic O_COMPARATOR_POWER,
  output logic O_BANDGAP_SELECT,
  output logic O_NEG_FROM_CHANNEL,
  output logic [2:0] O_NEG_CHANNEL,
  // Interrupt
  input wire logic I_GLOBAL_IRQ_ENABLE,
  input wire logic I_VECTOR_ACK,
  output logic O_IRQ,
  // Timer capture front end
  output logic O_CAPTURE_SOURCE,
  output logic O_CAPTURE_ROUTE_ENABLE,
  // Comparator pins digital path
  input wire logic I_POS_PIN_DIGITAL,
  input wire logic I_NEG_PIN_DIGITAL,
  output logic O_POS_PIN_BUFFER_EN,
  output logic O_NEG_PIN_BUFFER_EN,
  output logic O_POS_PIN_VALUE,
  output logic O_NEG_PIN_VALUE
);

  // ************************************************************
  // Register decode
  // ************************************************************
  wire hit_ctrl;
  wire hit_pins;
  wire wr_ctrl;
  wire wr_pins;
  wire rd_ctrl;
  wire rd_pins;

  assign hit_ctrl = I_IO_SPACE ? (I_ADDR == acc_pkg::CTRL_STATUS_IO_OFS) :
                    (I_ADDR == acc_pkg::CTRL_STATUS_DATA_OFS); // RULE18
  assign hit_pins = !I_IO_SPACE && (I_ADDR == acc_pkg::PIN_DISABLE_OFS);
  assign wr_ctrl = I_WR && hit_ctrl;
  assign wr_pins = I_WR && hit_pins;
  assign rd_ctrl = I_RD && hit_ctrl;
  assign rd_pins = I_RD && hit_pins;

  // ************************************************************
  // Control state
  // ************************************************************
  logic disable_reg;
  logic bandgap_reg;
  logic irq_enable_reg;
  logic capture_reg;
  logic [1:0] mode_reg;
  logic flag_reg;
  logic flag_next;
  logic [1:0] pin_dis_reg;
  logic result_prev_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Disable bit has no write lock, any cycle may change it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      disable_reg <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::BIT_DISABLE];
      bandgap_reg <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::BIT_BANDGAP];
      irq_enable_reg <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::BIT_IRQ_EN];
      capture_reg <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::BIT_CAPTURE];
      mode_reg <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO];
    end else if (wr_ctrl) begin
      disable_reg <= I_WDATA[acc_pkg::BIT_DISABLE]; // RULE4
      bandgap_reg <= I_WDATA[acc_pkg::BIT_BANDGAP];
      irq_enable_reg <= I_WDATA[acc_pkg::BIT_IRQ_EN];
      capture_reg <= I_WDATA[acc_pkg::BIT_CAPTURE];
      mode_reg <= I_WDATA[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_dis_reg <= acc_pkg::PIN_DISABLE_RESET;
    end else if (wr_pins) begin
      pin_dis_reg <= I_WDATA[acc_pkg::BIT_NEG_PIN_DIS:acc_pkg::BIT_POS_PIN_DIS];
    end
  end

  // ************************************************************
  // Input selection and raw comparison
  // ************************************************************
  wire use_channel;
  wire raw_vs_pin;
  wire raw_vs_channel;
  wire raw_result;

  // Converter enable overrides the mux: converter owns the channels
  assign use_channel = I_NEGATIVE_MUX_ENABLE && !I_CONVERTER_ENABLE; // RULE2 RULE3 RULE20
  assign raw_vs_pin = bandgap_reg ? I_BANDGAP_GT_NEG_PIN : I_POS_GT_NEG_PIN; // RULE6
  assign raw_vs_channel = bandgap_reg ? I_BANDGAP_GT_CHANNEL[I_CHANNEL_SELECT_LOW] :
                          I_POS_GT_CHANNEL[I_CHANNEL_SELECT_LOW]; // RULE2
  // Powered-down comparator reads low
  assign raw_result = !disable_reg && (use_channel ? raw_vs_channel : raw_vs_pin); // RULE1 RULE4

  // ************************************************************
  // Synchroniser and event detect
  // ************************************************************
  logic result_sync;

  acc_sync u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async(raw_result),
    .o_sync(result_sync)
  ); // RULE7

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      result_prev_reg <= 1'h0;
    end else begin
      result_prev_reg <= result_sync; // RULE21
    end
  end

  wire rise;
  wire fall;
  logic event_hit;

  assign rise = result_sync && !result_prev_reg; // RULE21
  assign fall = !result_sync && result_prev_reg;

  always_comb begin
    case (acc_pkg::acc_mode_t'(mode_reg))
      acc_pkg::ACC_MODE_TOGGLE: event_hit = rise || fall; // RULE14
      acc_pkg::ACC_MODE_FALL: event_hit = fall;
      acc_pkg::ACC_MODE_RISE: event_hit = rise;
      default: event_hit = 1'h0;
    endcase
  end

  // ************************************************************
  // Interrupt flag
  // ************************************************************
  wire flag_clear;

  assign flag_clear = I_VECTOR_ACK || (wr_ctrl && I_WDATA[acc_pkg::BIT_FLAG]); // RULE9

  // A new event in the clearing cycle must survive
  always_comb begin
    flag_next = flag_reg;
    if (flag_clear) begin
      flag_next = 1'h0;
    end
    if (event_hit) begin
      flag_next = 1'h1; // RULE8
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_reg <= acc_pkg::CTRL_STATUS_RESET[acc_pkg::BIT_FLAG];
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign O_IRQ = flag_reg && irq_enable_reg && I_GLOBAL_IRQ_ENABLE; // RULE10

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    rdata_next = 8'h00;
    if (rd_ctrl) begin
      rdata_next = {disable_reg, bandgap_reg, result_sync, flag_reg,
                    irq_enable_reg, capture_reg, mode_reg};
    end else if (rd_pins) begin
      rdata_next = {6'h00, pin_dis_reg};
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;

  // ************************************************************
  // Analog control, capture route and pin buffers
  // ************************************************************
  assign O_COMPARATOR_POWER = !disable_reg; // RULE4
  assign O_BANDGAP_SELECT = bandgap_reg; // RULE6
  assign O_NEG_FROM_CHANNEL = use_channel; // RULE2 RULE3
  assign O_NEG_CHANNEL = I_CHANNEL_SELECT_LOW;

  // Timer applies its own filter and edge select on this line
  assign O_CAPTURE_SOURCE = capture_reg && result_sync; // RULE11 RULE12
  assign O_CAPTURE_ROUTE_ENABLE = capture_reg; // RULE11 RULE12

  assign O_POS_PIN_BUFFER_EN = !pin_dis_reg[acc_pkg::BIT_POS_PIN_DIS]; // RULE16
  assign O_NEG_PIN_BUFFER_EN = !pin_dis_reg[acc_pkg::BIT_NEG_PIN_DIS];
  assign O_POS_PIN_VALUE = I_POS_PIN_DIGITAL && !pin_dis_reg[acc_pkg::BIT_POS_PIN_DIS]; // RULE16
  assign O_NEG_PIN_VALUE = I_NEG_PIN_DIGITAL && !pin_dis_reg[acc_pkg::BIT_NEG_PIN_DIS]; // RULE16

endmodule

// >>> pkg/acc_pkg.sv
package acc_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] CTRL_STATUS_DATA_OFS = 8'h50;
  localparam logic [7:0] IO_SPACE_SHIFT = 8'h20;
  localparam logic [7:0] CTRL_STATUS_IO_OFS = 8'h30;
  localparam logic [7:0] PIN_DISABLE_OFS = 8'h7f;

  // ************************************************************
  // Control/status field positions
  // ************************************************************
  localparam int BIT_DISABLE = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;

  // Pin input disable field positions
  localparam int BIT_NEG_PIN_DIS = 1;
  localparam int BIT_POS_PIN_DIS = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [1:0] PIN_DISABLE_RESET = 2'h0;

  // ************************************************************
  // Interrupt modes
  // ************************************************************
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RESERVED = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_t;

  // Synchroniser stages
  localparam int SYNC_STAGES = 2;

endpackage

// >>> hdl/acc_sync.sv
`timescale 1ns/100ps
module acc_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous level in, synchronised level out
  input wire logic i_async,
  output logic o_sync
);

  logic [acc_pkg::SYNC_STAGES-1:0] stage_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[acc_pkg::SYNC_STAGES-2:0], i_async};
    end
  end

  assign o_sync = stage_reg[acc_pkg::SYNC_STAGES-1];

endmodule

// >>> tb/acc_analog_model.sv
`timescale 1ns/100ps
module acc_analog_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Voltages
  input wire logic [7:0] i_pos_v,
  input wire logic [7:0] i_neg_v,
  input wire logic [7:0] i_bg_v,
  input wire logic [7:0] i_ch_base,
  // Comparisons
  output logic o_pos_gt_pin,
  output logic [7:0] o_pos_gt_ch,
  output logic o_bg_gt_pin,
  output logic [7:0] o_bg_gt_ch,
  // Timer capture front end
  input wire logic i_capture,
  output logic [7:0] o_capture_edges
);
  logic cap_reg;
  assign o_pos_gt_pin = i_pos_v > i_neg_v;
  assign o_bg_gt_pin = i_bg_v > i_neg_v;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      o_pos_gt_ch[n] = i_pos_v > (i_ch_base ^ 8'(n * 37));
      o_bg_gt_ch[n] = i_bg_v > (i_ch_base ^ 8'(n * 37));
    end
  end
  // Counts rising edges only, like an edge-select front end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cap_reg <= 1'h0;
      o_capture_edges <= 8'h00;
    end else begin
      cap_reg <= i_capture;
      o_capture_edges <= o_capture_edges + 8'(i_capture && !cap_reg);
    end
  end
endmodule

// >>> tb/acc_chk.sv
`timescale 1ns/100ps
module acc_chk (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Watched ports
  input wire logic [7:0] I_ADDR,
  input wire logic I_IO_SPACE,
  input wire logic I_WR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_NEGATIVE_MUX_ENABLE,
  input wire logic I_CONVERTER_ENABLE,
  input wire logic [2:0] I_CHANNEL_SELECT_LOW,
  input wire logic I_POS_GT_NEG_PIN,
  input wire logic I_GLOBAL_IRQ_ENABLE,
  input wire logic I_POS_PIN_DIGITAL,
  input wire logic O_COMPARATOR_POWER,
  input wire logic O_BANDGAP_SELECT,
  input wire logic O_NEG_FROM_CHANNEL,
  input wire logic [2:0] O_NEG_CHANNEL,
  input wire logic O_IRQ,
  input wire logic O_CAPTURE_SOURCE,
  input wire logic O_CAPTURE_ROUTE_ENABLE,
  input wire logic O_POS_PIN_BUFFER_EN,
  input wire logic O_POS_PIN_VALUE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire cs_wr = I_WR && (I_IO_SPACE ? I_ADDR == 8'h30 : I_ADDR == 8'h50);
  // Path from positive pin to capture output, all stages on
  wire pin_path = O_CAPTURE_ROUTE_ENABLE && O_COMPARATOR_POWER && !O_BANDGAP_SELECT && !O_NEG_FROM_CHANNEL;
  a_neg_select: assert property (O_NEG_FROM_CHANNEL == (I_NEGATIVE_MUX_ENABLE && !I_CONVERTER_ENABLE))
    else $error("negative input source wrong");
  a_channel_pass: assert property (O_NEG_FROM_CHANNEL |-> O_NEG_CHANNEL == I_CHANNEL_SELECT_LOW)
    else $error("negative channel index wrong");
  a_ctrl_write: assert property (cs_wr |=>
    {O_COMPARATOR_POWER, O_BANDGAP_SELECT, O_CAPTURE_ROUTE_ENABLE} ==
    {!$past(I_WDATA[7]), $past(I_WDATA[6]), $past(I_WDATA[2])}) else $error("control write not applied");
  a_capture_off: assert property (!O_CAPTURE_ROUTE_ENABLE |-> !O_CAPTURE_SOURCE)
    else $error("capture source leaks");
  a_sync_rise: assert property (
    pin_path && $rose(I_POS_GT_NEG_PIN) ##1 (pin_path && I_POS_GT_NEG_PIN) [*2] |-> O_CAPTURE_SOURCE)
    else $error("result rise late");
  a_sync_fall: assert property (
    pin_path && $fell(I_POS_GT_NEG_PIN) ##1 (pin_path && !I_POS_GT_NEG_PIN) [*2] |-> !O_CAPTURE_SOURCE)
    else $error("result fall late");
  a_irq_gate: assert property (O_IRQ |-> I_GLOBAL_IRQ_ENABLE)
    else $error("request without global enable");
  a_pin_value: assert property (O_POS_PIN_VALUE == (O_POS_PIN_BUFFER_EN && I_POS_PIN_DIGITAL))
    else $error("pin value not gated");
endmodule
bind acc_top acc_chk acc_chk_inst (.I_CLK, .I_RST, .I_ADDR, .I_IO_SPACE, .I_WR, .I_WDATA, .I_NEGATIVE_MUX_ENABLE,
  .I_CONVERTER_ENABLE, .I_CHANNEL_SELECT_LOW, .I_POS_GT_NEG_PIN, .I_GLOBAL_IRQ_ENABLE, .I_POS_PIN_DIGITAL,
  .O_COMPARATOR_POWER, .O_BANDGAP_SELECT, .O_NEG_FROM_CHANNEL, .O_NEG_CHANNEL, .O_IRQ, .O_CAPTURE_SOURCE,
  .O_CAPTURE_ROUTE_ENABLE, .O_POS_PIN_BUFFER_EN, .O_POS_PIN_VALUE);

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic I_CLK = 1'h0, I_RST = 1'h1, I_IO_SPACE = 1'h0, I_WR = 1'h0, I_RD = 1'h0, rd_d = 1'h0, gt, hit;
  logic [7:0] I_ADDR = 8'h00, I_WDATA = 8'h00, O_RDATA, I_POS_GT_CHANNEL, I_BANDGAP_GT_CHANNEL, edges, n0;
  logic I_NEGATIVE_MUX_ENABLE = 1'h0, I_CONVERTER_ENABLE = 1'h0, I_GLOBAL_IRQ_ENABLE = 1'h0, I_VECTOR_ACK = 1'h0;
  logic [2:0] I_CHANNEL_SELECT_LOW = 3'h0, O_NEG_CHANNEL;
  logic I_POS_GT_NEG_PIN, I_BANDGAP_GT_NEG_PIN, O_COMPARATOR_POWER, O_BANDGAP_SELECT, O_NEG_FROM_CHANNEL, O_IRQ;
  logic O_CAPTURE_SOURCE, O_CAPTURE_ROUTE_ENABLE, I_POS_PIN_DIGITAL = 1'h0, I_NEG_PIN_DIGITAL = 1'h0;
  logic O_POS_PIN_BUFFER_EN, O_NEG_PIN_BUFFER_EN, O_POS_PIN_VALUE, O_NEG_PIN_VALUE;
  logic [7:0] pos_v = 8'h10, neg_v = 8'h80, bg_v = 8'h40, ch_base = 8'h5a, exp_v;
  logic [7:0] exp_q[$];
  int fail_count = 0, check_count = 0;
  acc_top acc_top_inst (.I_CLK, .I_RST, .I_ADDR, .I_IO_SPACE, .I_WR, .I_RD, .I_WDATA, .O_RDATA,
    .I_NEGATIVE_MUX_ENABLE, .I_CONVERTER_ENABLE, .I_CHANNEL_SELECT_LOW, .I_POS_GT_NEG_PIN, .I_POS_GT_CHANNEL,
    .I_BANDGAP_GT_NEG_PIN, .I_BANDGAP_GT_CHANNEL, .O_COMPARATOR_POWER, .O_BANDGAP_SELECT, .O_NEG_FROM_CHANNEL,
    .O_NEG_CHANNEL, .I_GLOBAL_IRQ_ENABLE, .I_VECTOR_ACK, .O_IRQ, .O_CAPTURE_SOURCE, .O_CAPTURE_ROUTE_ENABLE,
    .I_POS_PIN_DIGITAL, .I_NEG_PIN_DIGITAL, .O_POS_PIN_BUFFER_EN, .O_NEG_PIN_BUFFER_EN, .O_POS_PIN_VALUE,
    .O_NEG_PIN_VALUE);
  acc_analog_model acc_analog_model_inst (.i_clk(I_CLK), .i_rst(I_RST), .i_pos_v(pos_v), .i_neg_v(neg_v),
    .i_bg_v(bg_v), .i_ch_base(ch_base), .o_pos_gt_pin(I_POS_GT_NEG_PIN), .o_pos_gt_ch(I_POS_GT_CHANNEL),
    .o_bg_gt_pin(I_BANDGAP_GT_NEG_PIN), .o_bg_gt_ch(I_BANDGAP_GT_CHANNEL), .i_capture(O_CAPTURE_SOURCE),
    .o_capture_edges(edges));
  initial forever #20 I_CLK = ~I_CLK;
  // ****************************************
  // Bus tasks, checking, verdict
  // ****************************************
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A read notes its expected value; the watcher compares it
  task bus(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_IO_SPACE <= io;
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= w;
    I_RD <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge I_CLK);
    I_WR <= 1'h0;
    I_RD <= 1'h0;
  endtask
  task volts(input logic [7:0] p);
    @(posedge I_CLK);
    pos_v <= p;
    repeat (4) @(posedge I_CLK);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge I_CLK) rd_d <= I_RD;
  always @(negedge I_CLK) if (rd_d) chk("read data", exp_q.pop_front(), O_RDATA);
  initial begin
    repeat (20000) @(posedge I_CLK);
    fail_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(88));
    repeat (12) @(posedge I_CLK);
    I_RST <= 1'h0;
    bus(0, 0, 8'h50, 8'h00);
    bus(0, 1, 8'h30, 8'h00);
    bus(0, 0, 8'h7f, 8'h00);
    bus(0, 0, 8'h51, 8'h00);
    bus(1, 0, 8'h7f, 8'hff);
    bus(0, 0, 8'h7f, 8'h03);
    @(posedge I_CLK);
    I_POS_PIN_DIGITAL <= 1'h1;
    I_NEG_PIN_DIGITAL <= 1'h1;
    @(negedge I_CLK);
    chk("pins", 8'h00, 8'({O_POS_PIN_VALUE, O_NEG_PIN_VALUE, O_POS_PIN_BUFFER_EN, O_NEG_PIN_BUFFER_EN}));
    bus(1, 0, 8'h7f, 8'h00);
    @(negedge I_CLK);
    chk("pins", 8'h0f, 8'({O_POS_PIN_VALUE, O_NEG_PIN_VALUE, O_POS_PIN_BUFFER_EN, O_NEG_PIN_BUFFER_EN}));
    // Reserved mode keeps the flag quiet while inputs move
    for (int i = 0; i < 10; i++) begin
      bus(1, 0, 8'h50, (i == 9) ? 8'h41 : 8'h01);
      @(posedge I_CLK);
      I_NEGATIVE_MUX_ENABLE <= 1'h1;
      I_CONVERTER_ENABLE <= (i >= 8);
      I_CHANNEL_SELECT_LOW <= 3'(i);
      pos_v <= 8'($urandom);
      bg_v <= 8'($urandom);
      neg_v <= 8'($urandom);
      ch_base <= 8'($urandom);
      repeat (4) @(posedge I_CLK);
      exp_v = (i < 8) ? (ch_base ^ 8'(i * 37)) : neg_v;
      gt = ((i == 9) ? bg_v : pos_v) > exp_v;
      chk("neg from channel", 8'(i < 8), 8'(O_NEG_FROM_CHANNEL));
      bus(0, 0, 8'h50, {1'h0, i == 9, gt, 5'h01});
    end
    bus(1, 0, 8'h50, 8'h11);
    @(posedge I_CLK);
    neg_v <= 8'h80;
    volts(8'h20);
    for (int m = 0; m < 4; m++) begin
      bus(1, 0, 8'h50, 8'h10 | 8'(m));
      for (int r = 1; r >= 0; r--) begin
        volts(r ? 8'hc0 : 8'h20);
        hit = (m == 0) || (m == 2 + r);
        bus(0, 0, 8'h50, {2'h0, r[0], hit, 2'h0, 2'(m)});
        bus(1, 0, 8'h50, 8'h10 | 8'(m));
      end
    end
    bus(1, 0, 8'h50, 8'h1b);
    @(posedge I_CLK);
    I_GLOBAL_IRQ_ENABLE <= 1'h1;
    volts(8'hc0);
    chk("irq", 8'h01, 8'(O_IRQ));
    I_GLOBAL_IRQ_ENABLE <= 1'h0;
    @(negedge I_CLK);
    chk("irq", 8'h00, 8'(O_IRQ));
    @(posedge I_CLK);
    I_GLOBAL_IRQ_ENABLE <= 1'h1;
    I_VECTOR_ACK <= 1'h1;
    @(posedge I_CLK);
    I_VECTOR_ACK <= 1'h0;
    @(negedge I_CLK);
    chk("irq", 8'h00, 8'(O_IRQ));
    bus(0, 0, 8'h50, 8'h2b);
    volts(8'h20);
    n0 = edges;
    bus(1, 1, 8'h30, 8'h04);
    for (int k = 0; k < 3; k++) begin
      volts(8'hc0);
      volts(8'h20);
    end
    chk("capture edges", n0 + 8'h03, edges);
    volts(8'hc0);
    bus(1, 0, 8'h50, 8'h94);
    repeat (4) @(posedge I_CLK);
    bus(0, 0, 8'h50, 8'h94);
    bus(1, 0, 8'h50, 8'h10);
    n0 = edges;
    volts(8'h20);
    volts(8'hc0);
    chk("capture edges", n0, edges);
    for (int t = 0; t < 8 && exp_q.size() > 0; t++) @(negedge I_CLK);
    if (exp_q.size() > 0) fail_count++;
    wrap_up;
  end
endmodule
